// >>> hdl/ilu_top.sv
// ilu_top: per-source pending latches, enable register group, global
// enable save and restore, vector relocation and watchdog action select.
// assumes sfr strobes and core handshakes are synchronous to REF_CLK.
//
// Operation
// RQ1 - one latch per source, set on request
// RQ2 - latched request goes out only when enabled
// RQ3 - acceptance clears that source latch at once
// RQ4 - reset clears all pending latches
// RQ5 - latches at four consecutive sfr bytes
// RQ6 - writing zero clears only that latch
// RQ7 - writing one never sets a latch
// RQ8 - second and watchdog latches ignore writes
// RQ9 - all latches readable by software; the second latch (bit 2) reads back as zero
// RQ10 - software avoids read-modify-write on latches
// RQ11 - software masks globally before changing enables
// RQ12 - nonmaskable sources bypass all enable bits
// RQ13 - enable group four bytes, fully read/write; code keeps only bits 7:4 and 0 of the low byte and bits 1:0 of the top byte
// RQ14 - global enable zero blocks maskable interrupts
// RQ15 - acceptance stacks then clears global enable
// RQ16 - return ops reload global enable from stack
// RQ17 - global enable bit0, unmask/mask ops, r/w
// RQ18 - reset clears global enable
// RQ19 - source enable bit gates its interrupt
// RQ20 - reset clears all source enable bits
// RQ21 - relocation and ram bits select ram vectors
// RQ22 - watchdog interrupts only when action bit zero
// RQ23 - maskable needs latch, source and global enables
`timescale 1ns/1ns
module ilu_top
    import ilu_pkg::*;
(
    input  wire logic                REF_CLK,
    input  wire logic                RSTN,
    input  wire logic [ilu_pkg::NUM_SRC-1:0] SRC_REQ,
    input  wire logic                WDT_EXPIRE,
    input  wire logic                SFR_WR,
    input  wire logic                SFR_RD,
    input  wire logic [11:0]         SFR_ADDR,
    input  wire logic [7:0]          SFR_WDATA,
    input  wire logic                ACCEPT,
    input  wire logic [4:0]          ACCEPT_SRC,
    input  wire logic                UNMASK_OP,
    input  wire logic                MASK_OP,
    input  wire logic                RETURN_OP,
    input  wire logic                STACKED_GLOBAL_EN,
    output logic [7:0]               SFR_RDATA,
    output logic [ilu_pkg::NUM_SRC-1:0] INT_REQ,
    output logic                     INT_PENDING,
    output logic                     STACK_GLOBAL_EN,
    output logic                     GLOBAL_EN,
    output logic                     VECTOR_IN_RAM,
    output logic                     VECTOR_RELOCATED,
    output logic                     WDT_RESET_REQ
);
    import ilu_pkg::*;

    // ========================================================
    // state
    typedef struct packed {
        logic [NUM_SRC-1:0] pend;
        logic [NUM_SRC-1:0] src_en;
        logic               global_en;
        logic               relocate;
        logic               ram_area;
        logic               wd_action;
        logic               stack_en;
        logic               wd_reset;
        logic [7:0]         rdata;
    } ilu_state_t;

    ilu_state_t st;
    ilu_state_t next_st;

    logic [NUM_SRC-1:0] req;
    logic [NUM_SRC-1:0] sw_clear;
    logic [NUM_SRC-1:0] acc_clear;
    logic [31:0]        pend_word;
    logic [31:0]        en_word;

    assign pend_word = {6'd0, st.pend};
    assign en_word   = {6'd0, st.src_en[NUM_SRC-1:FIRST_MASKABLE],
                        3'd0, st.global_en};

    // ========================================================
    // request gating
    always_comb begin
        req = st.pend;
        // RQ23 maskable three-way gate
        // RQ2 gated toward core
        // RQ14 global enable gate
        // RQ19 per-source gate
        for (int i = FIRST_MASKABLE; i < NUM_SRC; i++) begin
            req[i] = st.pend[i] & st.src_en[i] & st.global_en;
        end
        // RQ12 nonmaskable bypass enables
        req[1:0] = 2'b00;
        req[SRC_SECOND]   = st.pend[SRC_SECOND];
        req[SRC_WATCHDOG] = st.pend[SRC_WATCHDOG];
    end

    // ========================================================
    // next state
    always_comb begin
        next_st  = st;
        sw_clear = '0;
        acc_clear = '0;

        // RQ5 four latch bytes
        // RQ6 zero clears single bit
        // RQ7 ones leave latch alone
        if (SFR_WR) begin
            if (SFR_ADDR == ADDR_PEND_LOW) begin
                sw_clear[7:4] = ~SFR_WDATA[7:4];
            end else if (SFR_ADDR == ADDR_PEND_HIGH) begin
                sw_clear[15:8] = ~SFR_WDATA;
            end else if (SFR_ADDR == ADDR_PEND_EXT) begin
                sw_clear[23:16] = ~SFR_WDATA;
            end else if (SFR_ADDR == ADDR_PEND_TOP) begin
                sw_clear[25:24] = ~SFR_WDATA[1:0];
            end
        end
        // RQ8 fixed latches write-protected
        sw_clear[SRC_SECOND]   = 1'b0;
        sw_clear[SRC_WATCHDOG] = 1'b0;

        // RQ3 clear on acceptance
        if (ACCEPT && (int'(ACCEPT_SRC) < NUM_SRC)) begin
            acc_clear[ACCEPT_SRC] = 1'b1;
        end

        // RQ1 set on request, set wins
        next_st.pend = (st.pend & ~sw_clear & ~acc_clear) | SRC_REQ;
        // RQ22 watchdog event routing
        next_st.wd_reset = WDT_EXPIRE & st.wd_action;
        if (WDT_EXPIRE && !st.wd_action) begin
            next_st.pend[SRC_WATCHDOG] = 1'b1;
        end
        next_st.pend[1:0] = 2'b00;

        // RQ13 enable group writes
        // RQ17 global enable at bit 0
        if (SFR_WR) begin
            if (SFR_ADDR == ADDR_EN_LOW) begin
                next_st.src_en[7:4] = SFR_WDATA[7:4];
                next_st.global_en   = SFR_WDATA[GLOBAL_EN_POS];
            end else if (SFR_ADDR == ADDR_EN_HIGH) begin
                next_st.src_en[15:8] = SFR_WDATA;
            end else if (SFR_ADDR == ADDR_EN_EXT) begin
                next_st.src_en[23:16] = SFR_WDATA;
            end else if (SFR_ADDR == ADDR_EN_TOP) begin
                next_st.src_en[25:24] = SFR_WDATA[1:0];
            end else if (SFR_ADDR == ADDR_SYSCFG3) begin
                next_st.relocate = SFR_WDATA[RELOCATE_POS];
                next_st.ram_area = SFR_WDATA[RAM_AREA_POS];
            end else if (SFR_ADDR == ADDR_WDCTL) begin
                next_st.wd_action = SFR_WDATA[WD_ACTION_POS];
            end
        end
        // RQ17 unmask and mask ops
        if (UNMASK_OP) begin
            next_st.global_en = 1'b1;
        end else if (MASK_OP) begin
            next_st.global_en = 1'b0;
        end
        // RQ16 reload on return
        if (RETURN_OP) begin
            next_st.global_en = STACKED_GLOBAL_EN;
        end
        // RQ15 stack then clear
        if (ACCEPT) begin
            next_st.stack_en  = st.global_en;
            next_st.global_en = 1'b0;
        end

        // RQ9 latches readable, except the second latch bit, which reads zero
        next_st.rdata = ZERO_BYTE;
        if (SFR_RD) begin
            if (SFR_ADDR == ADDR_PEND_LOW) begin
                next_st.rdata = {pend_word[7:3], 3'b000};
            end else if (SFR_ADDR == ADDR_PEND_HIGH) begin
                next_st.rdata = pend_word[15:8];
            end else if (SFR_ADDR == ADDR_PEND_EXT) begin
                next_st.rdata = pend_word[23:16];
            end else if (SFR_ADDR == ADDR_PEND_TOP) begin
                next_st.rdata = pend_word[31:24];
            end else if (SFR_ADDR == ADDR_EN_LOW) begin
                next_st.rdata = en_word[7:0];
            end else if (SFR_ADDR == ADDR_EN_HIGH) begin
                next_st.rdata = en_word[15:8];
            end else if (SFR_ADDR == ADDR_EN_EXT) begin
                next_st.rdata = en_word[23:16];
            end else if (SFR_ADDR == ADDR_EN_TOP) begin
                next_st.rdata = en_word[31:24];
            end else if (SFR_ADDR == ADDR_SYSCFG3) begin
                next_st.rdata = {6'd0, st.ram_area, st.relocate};
            end else if (SFR_ADDR == ADDR_WDCTL) begin
                next_st.rdata = {7'd0, st.wd_action};
            end
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            // RQ4 latches cleared
            st.pend      <= PEND_RESET;
            // RQ20 source enables cleared
            st.src_en    <= EN_RESET;
            // RQ18 global enable cleared
            st.global_en <= 1'b0;
            st.relocate  <= 1'b0;
            st.ram_area  <= 1'b0;
            st.wd_action <= WD_ACTION_RESET;
            st.stack_en  <= 1'b0;
            st.wd_reset  <= 1'b0;
            st.rdata     <= ZERO_BYTE;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // outputs
    assign INT_REQ          = req;
    assign INT_PENDING      = |req;
    assign SFR_RDATA        = st.rdata;
    assign STACK_GLOBAL_EN  = st.stack_en;
    assign GLOBAL_EN        = st.global_en;
    assign VECTOR_RELOCATED = st.relocate;
    // RQ21 ram vector select
    assign VECTOR_IN_RAM    = st.relocate & st.ram_area;
    assign WDT_RESET_REQ    = st.wd_reset;

endmodule

// >>> pkg/ilu_pkg.sv
// ilu_pkg: constants for the interrupt latch and enable unit.
// assumes an 8-bit special-function register port inside the cpu core.
package ilu_pkg;

    // ========================================================
    // register addresses
    localparam logic [11:0] ADDR_PEND_LOW  = 12'h0FE0;
    localparam logic [11:0] ADDR_PEND_HIGH = 12'h0FE1;
    localparam logic [11:0] ADDR_PEND_EXT  = 12'h0FE2;
    localparam logic [11:0] ADDR_PEND_TOP  = 12'h0FE3;
    localparam logic [11:0] ADDR_EN_LOW    = 12'h003A;
    localparam logic [11:0] ADDR_EN_HIGH   = 12'h003B;
    localparam logic [11:0] ADDR_EN_EXT    = 12'h003C;
    localparam logic [11:0] ADDR_EN_TOP    = 12'h003D;
    localparam logic [11:0] ADDR_SYSCFG3   = 12'h0FD3;
    localparam logic [11:0] ADDR_WDCTL     = 12'h0FD4;

    // ========================================================
    // source numbering and field positions
    localparam int NUM_SRC        = 26;
    localparam int SRC_SECOND     = 2;
    localparam int SRC_WATCHDOG   = 3;
    localparam int FIRST_MASKABLE = 4;
    localparam int GLOBAL_EN_POS  = 0;
    localparam int RELOCATE_POS   = 0;
    localparam int RAM_AREA_POS   = 1;
    localparam int WD_ACTION_POS  = 0;

    // ========================================================
    // reset values
    localparam logic [25:0] PEND_RESET = 26'h000_0000;
    localparam logic [25:0] EN_RESET   = 26'h000_0000;
    localparam logic        WD_ACTION_RESET = 1'b1;
    localparam logic [7:0]  ZERO_BYTE  = 8'h00;

endpackage

// >>> verification/ilu_checker.sv
// ilu_checker: port timing relations of ilu_top.
// assumes binding to ilu_top with ports of the same names.
`timescale 1ns/1ns
module ilu_checker
    import ilu_pkg::*;
(
    input wire logic REF_CLK, RSTN, WDT_EXPIRE, SFR_RD, ACCEPT, MASK_OP,
    input wire logic UNMASK_OP, RETURN_OP, STACKED_GLOBAL_EN, GLOBAL_EN,
    input wire logic INT_PENDING, STACK_GLOBAL_EN, WDT_RESET_REQ,
    input wire logic [4:0] ACCEPT_SRC,
    input wire logic [7:0] SFR_RDATA,
    input wire logic [ilu_pkg::NUM_SRC-1:0] SRC_REQ, INT_REQ
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    chk_gate_global: assert property (|INT_REQ[25:4] |-> GLOBAL_EN)
        else $error("masked source raised");
    chk_pend_or: assert property (INT_PENDING == |INT_REQ)
        else $error("pending flag wrong");
    chk_accept_stack: assert property (ACCEPT |=>
        !GLOBAL_EN && STACK_GLOBAL_EN == $past(GLOBAL_EN)) else $error("stack");
    chk_latch_clear: assert property (ACCEPT && ACCEPT_SRC < 5'h1A &&
        !SRC_REQ[ACCEPT_SRC] && !WDT_EXPIRE |=> !INT_REQ[$past(ACCEPT_SRC)])
        else $error("latch kept after accept");
    chk_return_load: assert property (RETURN_OP && !ACCEPT |=>
        GLOBAL_EN == $past(STACKED_GLOBAL_EN)) else $error("return load");
    chk_unmask_set: assert property (UNMASK_OP && !MASK_OP &&
        !ACCEPT && !RETURN_OP |=> GLOBAL_EN) else $error("unmask");
    chk_mask_clr: assert property (MASK_OP && !UNMASK_OP &&
        !ACCEPT && !RETURN_OP |=> !GLOBAL_EN) else $error("mask");
    chk_bypass_set: assert property (SRC_REQ[2] |=> INT_REQ[2])
        else $error("fixed source not raised");
    chk_wdt_cause: assert property (WDT_RESET_REQ |-> $past(WDT_EXPIRE))
        else $error("reset request without expiry");
    chk_rd_idle: assert property (!SFR_RD |=> SFR_RDATA == 8'h00)
        else $error("read data without read");
endmodule

// >>> verification/ilu_core_model.sv
// ilu_core_model: core that takes, serves and returns from interrupts.
// assumes INT_REQ already gated; on and lag come from the bench.
`timescale 1ns/1ns
module ilu_core_model
    import ilu_pkg::*;
(
    input wire logic REF_CLK, RSTN, on, STACK_GLOBAL_EN,
    input wire logic [3:0] lag,
    input wire logic [ilu_pkg::NUM_SRC-1:0] INT_REQ,
    output logic ACCEPT, RETURN_OP, STACKED_GLOBAL_EN,
    output logic [4:0] ACCEPT_SRC
);
    logic [3:0] cnt;
    logic       busy;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            {ACCEPT, RETURN_OP, STACKED_GLOBAL_EN, busy, cnt, ACCEPT_SRC} <= '0;
        end else begin
            ACCEPT <= 1'b0;
            RETURN_OP <= 1'b0;
            if (busy) begin
                cnt <= cnt + 4'h1;
                busy <= cnt != lag;
                if (cnt == 4'h1) STACKED_GLOBAL_EN <= STACK_GLOBAL_EN;
                if (cnt == lag) RETURN_OP <= 1'b1;
            end else if (on && |INT_REQ) begin
                ACCEPT <= 1'b1;
                busy <= 1'b1;
                cnt <= 4'h0;
                for (int i = NUM_SRC - 1; i >= 0; i--)
                    if (INT_REQ[i]) ACCEPT_SRC <= 5'(i);
            end
        end
    end
endmodule

// >>> verification/ilu_top_bench.sv
// ilu_top_bench: random and directed checks of ilu_top.
// assumes ilu_core_model as the core; ilu_checker bound at the foot.
`timescale 1ns/1ns
module ilu_top_bench;
    import ilu_pkg::*;
    logic REF_CLK, RSTN, SFR_WR, SFR_RD, WDT_EXPIRE, UNMASK_OP, MASK_OP;
    logic ACCEPT, RETURN_OP, STACKED_GLOBAL_EN, STACK_GLOBAL_EN, GLOBAL_EN;
    logic VECTOR_IN_RAM, VECTOR_RELOCATED, WDT_RESET_REQ, INT_PENDING, on, g;
    logic [3:0]         lag;
    logic [4:0]         ACCEPT_SRC;
    logic [7:0]         SFR_WDATA, SFR_RDATA;
    logic [11:0]        SFR_ADDR;
    logic [NUM_SRC-1:0] SRC_REQ, INT_REQ, pm;
    logic [31:0]        ev;
    int                 mismatches, check_count, k;
    localparam logic [7:0] EMASK [4] = '{8'hF1, 8'hFF, 8'hFF, 8'h03};
    ilu_top ilu_top_inst (.*);
    ilu_core_model ilu_core_model_inst (.*);
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr_b(logic [11:0] a, logic [7:0] d);
        @(posedge REF_CLK);
        SFR_WR <= 1'b1;
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        @(posedge REF_CLK);
        SFR_WR <= 1'b0;
        #1;
    endtask
    task automatic rd_b(logic [11:0] a, logic [7:0] e);
        @(posedge REF_CLK);
        SFR_RD <= 1'b1;
        SFR_ADDR <= a;
        @(posedge REF_CLK);
        SFR_RD <= 1'b0;
        #1;
        chk("rdata", 32'(SFR_RDATA), 32'(e));
    endtask
    task automatic pulse(logic [25:0] r, logic x);
        @(posedge REF_CLK);
        SRC_REQ <= r;
        WDT_EXPIRE <= x;
        @(posedge REF_CLK);
        SRC_REQ <= '0;
        WDT_EXPIRE <= 1'b0;
        #1;
        pm = pm | (r & 26'h3FF_FFFC);
    endtask
    task automatic gop(logic u);
        @(posedge REF_CLK);
        UNMASK_OP <= u;
        MASK_OP <= !u;
        @(posedge REF_CLK);
        UNMASK_OP <= 1'b0;
        MASK_OP <= 1'b0;
        #1;
        g = u;
    endtask
    task automatic en_wr(int b, logic [7:0] d);
        wr_b(ADDR_EN_LOW + 12'(b), d);
        ev[8*b +: 8] = d & EMASK[b];
        rd_b(ADDR_EN_LOW + 12'(b), ev[8*b +: 8]);
    endtask
    task automatic pl_wr(int b, logic [7:0] d);
        logic [31:0] m;
        logic [31:0] v;
        wr_b(ADDR_PEND_LOW + 12'(b), d);
        m = ~(32'h0000_00FF << 8*b) | (32'(d) << 8*b) | 32'h0000_000C;
        pm = pm & m[25:0];
        v = 32'(pm) & 32'h03FF_FFF8;
        for (int j = 0; j < 4; j++)
            rd_b(ADDR_PEND_LOW + 12'(j), v[8*j +: 8]);
    endtask
    task automatic cmp();
        logic [25:0] e;
        e = (pm & ev[25:0] & 26'h3FF_FFF0 & {26{g}}) | (pm & 26'h00C);
        chk("global", 32'(GLOBAL_EN), 32'(g));
        chk("int_req", 32'(INT_REQ), 32'(e));
        chk("pending", 32'(INT_PENDING), 32'(|e));
    endtask
    task automatic hit(logic a);
        for (int n = 0; n < 300; n++) begin
            @(posedge REF_CLK);
            #1;
            if ((a ? ACCEPT : RETURN_OP) === 1'b1) begin
                @(posedge REF_CLK);
                #1;
                return;
            end
        end
        mismatches++;
        results();
    endtask
    initial begin
        {SFR_WR, SFR_RD, WDT_EXPIRE, UNMASK_OP, MASK_OP, on, g, RSTN} = '0;
        {SFR_ADDR, SFR_WDATA, SRC_REQ, pm, ev} = '0;
        lag = 4'h2;
        mismatches = 0;
        check_count = 0;
        void'($urandom(32'hb7b82e8c));
        repeat (16) @(posedge REF_CLK);
        RSTN <= 1'b1;
        pl_wr(0, 8'hFF);
        for (k = 0; k < 4; k++)
            rd_b(ADDR_EN_LOW + 12'(k), 8'h00);
        cmp();
        wr_b(12'h0123, 8'hFF);
        rd_b(12'h0123, 8'h00);
        // global masked around every latch or enable change
        repeat (24) begin
            gop(1'b0);
            pulse(26'($urandom), 1'b0);
            en_wr($urandom_range(3), 8'($urandom) & 8'hFE);
            pl_wr($urandom_range(3), 8'($urandom));
            gop(1'($urandom));
            cmp();
        end
        pl_wr(0, 8'h00);
        pl_wr(1, 8'hFF);
        wr_b(ADDR_SYSCFG3, 8'h03);
        chk("vector", 32'({VECTOR_IN_RAM, VECTOR_RELOCATED}), 32'h3);
        wr_b(ADDR_SYSCFG3, 8'h02);
        chk("vector", 32'({VECTOR_IN_RAM, VECTOR_RELOCATED}), 32'h0);
        pulse('0, 1'b1);
        chk("wdt_reset", 32'(WDT_RESET_REQ), 32'h1);
        wr_b(ADDR_WDCTL, 8'h00);
        pulse('0, 1'b1);
        pm[3] = 1'b1;
        chk("wdt_reset", 32'(WDT_RESET_REQ), 32'h0);
        pl_wr(0, 8'h00);
        @(posedge REF_CLK);
        RSTN <= 1'b0;
        repeat (3) @(posedge REF_CLK);
        RSTN <= 1'b1;
        {pm, ev, g} = '0;
        lag = 4'($urandom_range(15, 2));
        en_wr(1, 8'h01);
        pulse(26'h000_0104, 1'b0);
        @(posedge REF_CLK);
        on <= 1'b1;
        hit(1'b1);
        chk("stacked", 32'({GLOBAL_EN, STACK_GLOBAL_EN}), 32'h0);
        chk("int_req", 32'(INT_REQ), 32'h0);
        hit(1'b0);
        chk("global", 32'(GLOBAL_EN), 32'h0);
        gop(1'b1);
        hit(1'b1);
        chk("stacked", 32'({GLOBAL_EN, STACK_GLOBAL_EN}), 32'h1);
        hit(1'b0);
        chk("global", 32'(GLOBAL_EN), 32'h1);
        pm = '0;
        pl_wr(1, 8'hFF);
        results();
    end
endmodule
bind ilu_top ilu_checker ilu_checker_inst (.*);
